// ==== design/async_mem_write_cycle_ctrl.sv ====
// Write-cycle sequencer for an asynchronous memory port, normal and select-strobe modes
// Functional notes
// - Strobe start: write strobe low, byte enables valid
// - Strobe end edge: strobe high, enables off
// - Active wait input stretches the strobe period
// - Hold end: address, bank, data become invalid
// - Select rises at hold end if no more cycles
// - Narrow bus: extra cycles until word done
// - Follow-on cycles go straight to setup
// - Pending request at word end: enter turnaround directly
// - Region strobe-select bit one selects select-strobe
// - Select-strobe: select asserted only during strobe
// - Turnaround count; none after write, configured count (at least one) after read
// - Recheck priority after turnaround, else abandon
// - Setup start: load counts, drive bus, select low unless select-strobe
`timescale 1ns/1ps
module async_mem_write_cycle_ctrl #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter int BE_W = 2,
  parameter int CYC_W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write request from the internal arbiter, held until accepted
  input wire logic req_valid,
  input wire logic req_top_prio,
  input wire logic [1:0] req_region,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_bank,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic [BE_W-1:0] req_be_n,
  input wire logic [CYC_W-1:0] req_cycles,
  input wire logic prev_was_read,
  output logic req_accept,
  output logic word_done,
  output logic abandoned,
  output logic busy,
  // Next-beat data from the requester for split accesses
  input wire logic [DATA_W-1:0] next_data,
  input wire logic [BE_W-1:0] next_be_n,
  // Per-region configuration
  input wire logic [async_wr_pkg::NUM_REGIONS*async_wr_pkg::CFG_W-1:0] region_config,
  // External device pins
  input wire logic external_wait_in,
  output logic write_strobe_n,
  output logic [BE_W-1:0] byte_enable_n,
  output logic [async_wr_pkg::NUM_REGIONS-1:0] region_select_n,
  output logic [ADDR_W-1:0] addr_out,
  output logic [1:0] bank_addr_out,
  output logic [DATA_W-1:0] data_io_out,
  output logic data_io_oe_n
);
  initial begin
    if (async_wr_pkg::CFG_SETUP_LSB + async_wr_pkg::SETUP_W > async_wr_pkg::CFG_W)
      $error("region_config field layout too wide");
    if (CYC_W < 1 || ADDR_W < 1 || DATA_W < 8 || BE_W * 8 != DATA_W)
      $error("unsupported width parameters");
  end

  // Pin wait input synchroniser
  logic wait_s1_q, wait_s2_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_s1_q <= 1'h0;
      wait_s2_q <= 1'h0;
    end else begin
      wait_s1_q <= external_wait_in;
      wait_s2_q <= wait_s1_q;
    end
  end

  // Field extraction for the requested region
  logic [async_wr_pkg::CFG_W-1:0] cfg_sel;
  logic cfg_ss;
  logic [async_wr_pkg::TA_W-1:0] cfg_ta;
  logic [async_wr_pkg::SETUP_W-1:0] cfg_setup;
  logic [async_wr_pkg::STROBE_W-1:0] cfg_strobe;
  logic [async_wr_pkg::HOLD_W-1:0] cfg_hold;
  always_comb begin
    cfg_sel = region_config[req_region*async_wr_pkg::CFG_W +: async_wr_pkg::CFG_W];
    cfg_ss = cfg_sel[async_wr_pkg::CFG_SS_POS];
    cfg_ta = cfg_sel[async_wr_pkg::CFG_TA_LSB +: async_wr_pkg::TA_W];
    cfg_setup = cfg_sel[async_wr_pkg::CFG_SETUP_LSB +: async_wr_pkg::SETUP_W];
    cfg_strobe = cfg_sel[async_wr_pkg::CFG_STROBE_LSB +: async_wr_pkg::STROBE_W];
    cfg_hold = cfg_sel[async_wr_pkg::CFG_HOLD_LSB +: async_wr_pkg::HOLD_W];
  end

  // Sequencer state
  async_wr_pkg::wr_state_t state_q, state_d;
  logic [async_wr_pkg::STROBE_W-1:0] cnt_q, cnt_d;
  logic [async_wr_pkg::SETUP_W-1:0] ld_setup_q, ld_setup_d;
  logic [async_wr_pkg::STROBE_W-1:0] ld_strobe_q, ld_strobe_d;
  logic [async_wr_pkg::HOLD_W-1:0] ld_hold_q, ld_hold_d;
  logic [CYC_W-1:0] left_q, left_d;
  logic [1:0] region_q, region_d;
  logic ss_q, ss_d;
  logic last_wr_q, last_wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [1:0] bank_q, bank_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic [BE_W-1:0] be_q, be_d;
  logic [BE_W-1:0] be_pin_q, be_pin_d;
  logic we_q, we_d;
  logic oe_n_q, oe_n_d;
  logic [async_wr_pkg::NUM_REGIONS-1:0] sel_q, sel_d;
  logic accept_c, done_c, abandon_c;
  logic [async_wr_pkg::NUM_REGIONS-1:0] onehot;
  logic [async_wr_pkg::TA_W-1:0] ta_eff;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ld_setup_d = ld_setup_q;
    ld_strobe_d = ld_strobe_q;
    ld_hold_d = ld_hold_q;
    left_d = left_q;
    region_d = region_q;
    ss_d = ss_q;
    last_wr_d = last_wr_q;
    addr_d = addr_q;
    bank_d = bank_q;
    data_d = data_q;
    be_d = be_q;
    be_pin_d = be_pin_q;
    we_d = we_q;
    oe_n_d = oe_n_q;
    sel_d = sel_q;
    accept_c = 1'h0;
    done_c = 1'h0;
    abandon_c = 1'h0;
    onehot = '0;
    onehot[region_q] = 1'h1;
    ta_eff = cfg_ta;
    if (!prev_was_read && last_wr_q)
      ta_eff = async_wr_pkg::TA_ZERO;
    else if (prev_was_read && cfg_ta == async_wr_pkg::TA_ZERO)
      ta_eff = async_wr_pkg::TA_AFTER_READ_MIN;
    case (state_q)
      async_wr_pkg::ST_IDLE: begin
        we_d = async_wr_pkg::WE_IDLE_N;
        if (req_valid && req_top_prio) begin
          state_d = async_wr_pkg::ST_TURN;
          cnt_d = async_wr_pkg::STROBE_W'(ta_eff);
        end
      end
      async_wr_pkg::ST_TURN: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'h1;
        end else if (!(req_valid && req_top_prio)) begin
          state_d = async_wr_pkg::ST_IDLE;
          abandon_c = 1'h1;
        end else begin
          // Latch the whole request so the requester may move on
          accept_c = 1'h1;
          state_d = async_wr_pkg::ST_SETUP;
          ld_setup_d = cfg_setup;
          ld_strobe_d = cfg_strobe;
          ld_hold_d = cfg_hold;
          cnt_d = async_wr_pkg::STROBE_W'(cfg_setup);
          region_d = req_region;
          ss_d = (cfg_ss == async_wr_pkg::CFG_SS_ON);
          left_d = req_cycles;
          addr_d = req_addr;
          bank_d = req_bank;
          data_d = req_data;
          be_d = req_be_n;
          oe_n_d = 1'h0;
          sel_d = async_wr_pkg::SEL_IDLE_N;
          if (cfg_ss != async_wr_pkg::CFG_SS_ON) begin
            sel_d[req_region] = 1'h0;
          end
        end
      end
      async_wr_pkg::ST_SETUP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'h1;
        end else begin
          state_d = async_wr_pkg::ST_STROBE;
          cnt_d = ld_strobe_q;
          we_d = 1'h0;
          be_pin_d = be_q;
          if (ss_q)
            sel_d = ~onehot;
        end
      end
      async_wr_pkg::ST_STROBE: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'h1;
        end else if (!wait_s2_q) begin
          state_d = async_wr_pkg::ST_HOLD;
          cnt_d = async_wr_pkg::STROBE_W'(ld_hold_q);
          we_d = 1'h1;
          be_pin_d = '1;
          if (ss_q)
            sel_d = async_wr_pkg::SEL_IDLE_N;
        end
      end
      async_wr_pkg::ST_HOLD: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'h1;
        end else if (left_q != '0) begin
          // More beats of the same word
          left_d = left_q - 1'h1;
          state_d = async_wr_pkg::ST_SETUP;
          cnt_d = async_wr_pkg::STROBE_W'(ld_setup_q);
          addr_d = addr_q + 1'h1;
          data_d = next_data;
          be_d = next_be_n;
        end else begin
          done_c = 1'h1;
          last_wr_d = 1'h1;
          oe_n_d = 1'h1;
          addr_d = '0;
          bank_d = '0;
          data_d = '0;
          sel_d = async_wr_pkg::SEL_IDLE_N;
          if (req_valid && req_top_prio) begin
            state_d = async_wr_pkg::ST_TURN;
            // This word was a write, so only a read reported since then costs cycles
            if (prev_was_read)
              cnt_d = async_wr_pkg::STROBE_W'(ta_eff);
            else
              cnt_d = '0;
          end else begin
            state_d = async_wr_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_d = async_wr_pkg::ST_IDLE;
      end
    endcase
    if (prev_was_read)
      last_wr_d = 1'h0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= async_wr_pkg::ST_IDLE;
      cnt_q <= '0;
      ld_setup_q <= '0;
      ld_strobe_q <= '0;
      ld_hold_q <= '0;
      left_q <= '0;
      region_q <= async_wr_pkg::REGION_RST;
      ss_q <= 1'h0;
      last_wr_q <= 1'h0;
      addr_q <= '0;
      bank_q <= '0;
      data_q <= '0;
      be_q <= '1;
      be_pin_q <= '1;
      we_q <= async_wr_pkg::WE_IDLE_N;
      oe_n_q <= 1'h1;
      sel_q <= async_wr_pkg::SEL_IDLE_N;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ld_setup_q <= ld_setup_d;
      ld_strobe_q <= ld_strobe_d;
      ld_hold_q <= ld_hold_d;
      left_q <= left_d;
      region_q <= region_d;
      ss_q <= ss_d;
      last_wr_q <= last_wr_d;
      addr_q <= addr_d;
      bank_q <= bank_d;
      data_q <= data_d;
      be_q <= be_d;
      be_pin_q <= be_pin_d;
      we_q <= we_d;
      oe_n_q <= oe_n_d;
      sel_q <= sel_d;
    end
  end

  assign req_accept = accept_c;
  assign word_done = done_c;
  assign abandoned = abandon_c;
  assign busy = (state_q != async_wr_pkg::ST_IDLE);
  assign write_strobe_n = we_q;
  assign byte_enable_n = be_pin_q;
  assign region_select_n = sel_q;
  assign addr_out = addr_q;
  assign bank_addr_out = bank_q;
  assign data_io_out = data_q;
  assign data_io_oe_n = oe_n_q;

  // Checks
  sequence s_strobe_entry;
    state_q == async_wr_pkg::ST_SETUP && cnt_q == '0;
  endsequence
  a_strobe_falls: assert property (@(posedge clk) disable iff (!resetn)
    s_strobe_entry |=> !write_strobe_n && byte_enable_n == be_q)
    else $error("strobe not low with byte enables");
  a_strobe_rises: assert property (@(posedge clk) disable iff (!resetn)
    state_q == async_wr_pkg::ST_STROBE && $past(state_q) == async_wr_pkg::ST_STROBE ##1
    state_q == async_wr_pkg::ST_HOLD |-> write_strobe_n && byte_enable_n == '1)
    else $error("strobe end did not release");
  a_wait_extends: assert property (@(posedge clk) disable iff (!resetn)
    state_q == async_wr_pkg::ST_STROBE && cnt_q == '0 && wait_s2_q
    |=> state_q == async_wr_pkg::ST_STROBE && !write_strobe_n)
    else $error("wait did not extend strobe");
  a_hold_release: assert property (@(posedge clk) disable iff (!resetn)
    word_done |=> data_io_oe_n && region_select_n == async_wr_pkg::SEL_IDLE_N)
    else $error("bus not released after hold");
  a_split_setup: assert property (@(posedge clk) disable iff (!resetn)
    state_q == async_wr_pkg::ST_HOLD && cnt_q == '0 && left_q != '0
    |=> state_q == async_wr_pkg::ST_SETUP && cnt_q == $past(ld_setup_q))
    else $error("split cycle did not restart setup");
  a_ss_select: assert property (@(posedge clk) disable iff (!resetn)
    ss_q && state_q == async_wr_pkg::ST_SETUP |-> region_select_n == async_wr_pkg::SEL_IDLE_N)
    else $error("select active outside strobe");
  a_abandon: assert property (@(posedge clk) disable iff (!resetn)
    abandoned |=> state_q == async_wr_pkg::ST_IDLE)
    else $error("abandon did not idle");
  a_idle_high: assert property (@(posedge clk) disable iff (!resetn)
    state_q == async_wr_pkg::ST_IDLE |-> write_strobe_n)
    else $error("strobe low while idle");
endmodule

// ==== shared/async_wr_pkg.sv ====
// Shared constants and types for the asynchronous write-cycle sequencer
package async_wr_pkg;
  localparam int NUM_REGIONS = 4;
  localparam int FIRST_REGION = 2;
  localparam int SETUP_W = 4;
  localparam int STROBE_W = 6;
  localparam int HOLD_W = 3;
  localparam int TA_W = 2;
  // Field positions inside region_config
  localparam int CFG_SS_POS = 0;
  localparam int CFG_TA_LSB = 1;
  localparam int CFG_HOLD_LSB = 3;
  localparam int CFG_STROBE_LSB = 6;
  localparam int CFG_SETUP_LSB = 12;
  localparam int CFG_W = 16;
  localparam logic CFG_SS_ON = 1'h1;
  localparam logic [TA_W-1:0] TA_ZERO = 2'h0;
  localparam logic [TA_W-1:0] TA_AFTER_READ_MIN = 2'h1;
  localparam logic [1:0] REGION_RST = 2'h0;
  localparam logic [NUM_REGIONS-1:0] SEL_IDLE_N = 4'hF;
  localparam logic WE_IDLE_N = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_TURN   = 3'b001,
    ST_SETUP  = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100
  } wr_state_t;
endpackage

// ==== sim/ext_async_mem.sv ====
// Behavioural asynchronous device that latches writes and can stall the strobe
`timescale 1ns/1ps
module ext_async_mem (
  // Clock
  input wire logic clk,
  // Pins from the sequencer
  input wire logic write_strobe_n,
  input wire logic [21:0] addr_out,
  input wire logic [1:0] bank_addr_out,
  input wire logic [15:0] data_io_out,
  input wire logic data_io_oe_n,
  // Stall control and captured write
  input wire logic [3:0] stall_len,
  output logic external_wait_in,
  output logic [21:0] last_addr,
  output logic [15:0] last_data,
  output logic [1:0] last_bank
);
  logic [3:0] stall_q;
  initial begin
    external_wait_in = 1'h0;
    stall_q = 4'h0;
  end
  always @(posedge clk) begin
    if (write_strobe_n == 1'h0 && stall_q < stall_len) begin
      external_wait_in <= 1'h1; // Ask for a longer strobe
      stall_q <= stall_q + 4'h1;
    end else begin
      external_wait_in <= 1'h0;
      if (write_strobe_n) stall_q <= 4'h0;
    end
  end
  // An undriven bus reads back as garbage, never as the last value
  always @(posedge write_strobe_n) begin
    last_addr <= addr_out;
    last_bank <= bank_addr_out;
    last_data <= data_io_oe_n ? ~data_io_out : data_io_out;
  end
endmodule

// ==== sim/tb_async_mem_write_cycle_ctrl.sv ====
// Self-checking testbench for the asynchronous write-cycle sequencer
`timescale 1ns/1ps
module tb_async_mem_write_cycle_ctrl;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic req_valid = 1'h0;
  logic req_top_prio = 1'h1;
  logic prev_was_read = 1'h0;
  logic [1:0] req_region = 2'h0;
  logic [21:0] req_addr = 22'h0012A5;
  logic [1:0] req_bank = 2'h2;
  logic [15:0] req_data = 16'hC3A5;
  logic [1:0] req_be_n = 2'h2;
  logic [1:0] req_cycles = 2'h0;
  logic [15:0] next_data = 16'h5A3C;
  logic [1:0] next_be_n = 2'h1;
  logic [63:0] region_config = 64'h0;
  logic [3:0] stall_len = 4'h0;
  logic external_wait_in, req_accept, word_done, abandoned, busy, write_strobe_n;
  logic data_io_oe_n, we_prev;
  logic [1:0] byte_enable_n, bank_addr_out, last_bank;
  logic [3:0] region_select_n, sel_prev;
  logic [21:0] addr_out, last_addr;
  logic [15:0] data_io_out, last_data;
  int num_errors = 0;
  int checks = 0;
  int lat, base, we_low, sel_out, sel_rise, beats, be_bad, got_done, got_ab, accepts;

  always #2 clk = ~clk;

  async_mem_write_cycle_ctrl u_dut (.clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req_top_prio(req_top_prio), .req_region(req_region), .req_addr(req_addr),
    .req_bank(req_bank), .req_data(req_data), .req_be_n(req_be_n), .req_cycles(req_cycles),
    .prev_was_read(prev_was_read), .req_accept(req_accept), .word_done(word_done),
    .abandoned(abandoned), .busy(busy), .next_data(next_data), .next_be_n(next_be_n),
    .region_config(region_config), .external_wait_in(external_wait_in),
    .write_strobe_n(write_strobe_n), .byte_enable_n(byte_enable_n),
    .region_select_n(region_select_n), .addr_out(addr_out), .bank_addr_out(bank_addr_out),
    .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n));

  ext_async_mem u_mem (.clk(clk), .write_strobe_n(write_strobe_n), .addr_out(addr_out),
    .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n), .stall_len(stall_len),
    .external_wait_in(external_wait_in), .last_addr(last_addr), .last_data(last_data),
    .bank_addr_out(bank_addr_out), .last_bank(last_bank));

  function automatic logic [15:0] cfg(logic ss, logic [1:0] ta, logic [5:0] strobe);
    return {4'h1, strobe, 3'h1, ta, ss};
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Drives one request and tallies pin activity at each falling edge
  task automatic run(logic [1:0] region, logic [1:0] cycles, logic hold_req, logic drop);
    int n;
    {lat, we_low, sel_out, sel_rise, beats, be_bad, got_done, got_ab, accepts} = '0;
    sel_prev = 4'hF;
    we_prev = 1'h1;
    req_region = region;
    req_cycles = cycles;
    req_valid = 1'h1;
    for (n = 0; n < 200 && got_done == 0 && got_ab == 0; n++) begin
      @(negedge clk);
      if (req_accept === 1'h1 && lat == 0) lat = n + 1;
      accepts += (req_accept === 1'h1);
      beats += (write_strobe_n === 1'h0 && we_prev === 1'h1);
      we_low += (write_strobe_n === 1'h0);
      sel_out += (region_select_n[region] === 1'h0 && write_strobe_n === 1'h1);
      sel_rise += (sel_prev[region] === 1'h0 && region_select_n[region] === 1'h1);
      be_bad += (byte_enable_n !== (write_strobe_n ? 2'h3 : (beats > 1 ? next_be_n : req_be_n)));
      sel_prev = region_select_n;
      we_prev = write_strobe_n;
      got_done = (word_done === 1'h1);
      got_ab = (abandoned === 1'h1);
      @(posedge clk);
      #1;
      if ((lat != 0 && !hold_req) || got_ab != 0) req_valid = 1'h0;
      if (drop) req_top_prio = 1'h0;
    end
    // Select release lands on the edge after the done pulse, so look once more
    @(negedge clk);
    accepts += (req_accept === 1'h1);
    sel_rise += (sel_prev[region] === 1'h0 && region_select_n[region] === 1'h1);
    @(posedge clk);
    #1;
  endtask

  task automatic t_single();
    run(2'h0, 2'h0, 1'h0, 1'h0);
    base = lat;
    check("done", got_done, 1);
    check("beats", beats, 1);
    check("strobe_len", we_low, 4);
    check("be_bad", be_bad, 0);
    check("select_early", sel_out > 0, 1);
    check("addr", last_addr, req_addr);
    check("data", last_data, req_data);
    check("bank", last_bank, req_bank);
    check("select_rise", sel_rise, 1);
    @(negedge clk);
    check("oe_n", data_io_oe_n, 1'h1);
    check("select_idle", region_select_n, 4'hF);
    check("strobe_idle", write_strobe_n, 1'h1);
    check("busy", busy, 1'h0);
    @(posedge clk);
    #1;
  endtask

  task automatic t_turnaround();
    prev_was_read = 1'h1;
    run(2'h0, 2'h0, 1'h0, 1'h0);
    check("lat_read_ta0", lat, base + 1);
    run(2'h2, 2'h0, 1'h0, 1'h0);
    check("lat_read_ta3", lat, base + 3);
    prev_was_read = 1'h0;
    run(2'h0, 2'h0, 1'h0, 1'h0);
    check("lat_write_ta0", lat, base);
    run(2'h2, 2'h0, 1'h0, 1'h0);
    check("lat_write_ta3", lat, base);
    prev_was_read = 1'h1;
    run(2'h2, 2'h0, 1'h0, 1'h1);
    check("abandoned", got_ab, 1);
    check("abandon_beats", beats, 0);
    req_top_prio = 1'h1;
    prev_was_read = 1'h0;
  endtask

  task automatic t_select_strobe();
    run(2'h1, 2'h0, 1'h0, 1'h0);
    check("ss_outside", sel_out, 0);
    check("ss_rise", sel_rise, 1);
    check("ss_be", be_bad, 0);
    check("ss_data", last_data, req_data);
  endtask

  task automatic t_split();
    fork
      run(2'h0, 2'h1, 1'h0, 1'h0);
      begin
        repeat (6) @(posedge clk);
        #1;
        region_config[15:0] = cfg(1'h0, 2'h0, 6'h7);
      end
    join
    check("split_beats", beats, 2);
    check("split_strobe", we_low, 8);
    check("split_select", sel_rise, 1);
    check("split_addr", last_addr, req_addr + 22'h1);
    check("split_data", last_data, next_data);
    check("split_be", be_bad, 0);
    region_config[15:0] = cfg(1'h0, 2'h0, 6'h3);
  endtask

  task automatic t_wait_and_pending();
    stall_len = 4'h6;
    run(2'h0, 2'h0, 1'h0, 1'h0);
    check("wait_stretch", we_low > 4, 1);
    check("wait_data", last_data, req_data);
    stall_len = 4'h0;
    run(2'h0, 2'h0, 1'h1, 1'h0);
    check("pending_accept", accepts, 2);
    check("pending_busy", busy, 1'h1);
    req_valid = 1'h0;
    got_done = 0;
    repeat (20) begin
      @(negedge clk);
      got_done += (word_done === 1'h1);
    end
    check("pending_done", got_done, 1);
  endtask

  initial begin
    #20000;
    num_errors++;
    print_verdict();
  end

  initial begin
    region_config = {cfg(1'h0, 2'h0, 6'h3), cfg(1'h0, 2'h3, 6'h3), cfg(1'h1, 2'h0, 6'h3),
      cfg(1'h0, 2'h0, 6'h3)};
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'h1;
    @(posedge clk);
    #1;
    t_single();
    t_turnaround();
    t_select_strobe();
    t_split();
    t_wait_and_pending();
    print_verdict();
  end
endmodule
